// ### inc/tmr8_pkg.sv
// Constants, field positions and types of the eight-bit timer with waveform outputs.
// Assumes one I/O clock; register offsets are APB byte addresses of aligned words.
package tmr8_pkg;

  // Register byte offsets.
  localparam logic [7:0] TMR8_OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] TMR8_OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] TMR8_OFS_COUNT   = 8'h08;
  localparam logic [7:0] TMR8_OFS_CMP_A   = 8'h0c;
  localparam logic [7:0] TMR8_OFS_CMP_B   = 8'h10;
  localparam logic [7:0] TMR8_OFS_FLAGS   = 8'h14;
  localparam logic [7:0] TMR8_OFS_PORT    = 8'h18;

  // Reset values.
  localparam logic [7:0] TMR8_RST_CTRL_A  = 8'h00;
  localparam logic [7:0] TMR8_RST_CTRL_B  = 8'h00;
  localparam logic [7:0] TMR8_RST_BYTE    = 8'h00;

  // Field positions of timer_control_a.
  localparam int TMR8_A_BEH_HI = 7;
  localparam int TMR8_A_BEH_LO = 6;
  localparam int TMR8_B_BEH_HI = 5;
  localparam int TMR8_B_BEH_LO = 4;
  localparam logic [7:0] TMR8_CTRL_A_MASK = 8'hf3;
  // Field positions of timer_control_b.
  localparam int TMR8_FORCE_A   = 7;
  localparam int TMR8_FORCE_B   = 6;
  localparam int TMR8_MODE_BIT2 = 3;
  localparam logic [7:0] TMR8_CTRL_B_MASK = 8'h0f;
  // Field positions of the flag register.
  localparam int TMR8_FLAG_WRAP = 0;
  localparam int TMR8_FLAG_A    = 1;
  localparam int TMR8_FLAG_B    = 2;
  // Port register: bits 1:0 direction, bits 5:4 port data.
  localparam int TMR8_DIR_A  = 0;
  localparam int TMR8_DIR_B  = 1;
  localparam int TMR8_DATA_A = 4;
  localparam int TMR8_DATA_B = 5;
  localparam logic [7:0] TMR8_PORT_MASK = 8'h33;

  // Counter landmarks.
  localparam logic [7:0] TMR8_MAX    = 8'hff;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;

  // Prescaler terminal counts for divide by 8, 64, 256 and 1024.
  localparam logic [9:0] TMR8_DIV8    = 10'h007;
  localparam logic [9:0] TMR8_DIV64   = 10'h03f;
  localparam logic [9:0] TMR8_DIV256  = 10'h0ff;
  localparam logic [9:0] TMR8_DIV1024 = 10'h3ff;

  typedef enum logic [2:0] {
    TMR8_CS_STOP = 3'h0, TMR8_CS_DIV1 = 3'h1, TMR8_CS_DIV8 = 3'h2, TMR8_CS_DIV64 = 3'h3,
    TMR8_CS_DIV256 = 3'h4, TMR8_CS_DIV1024 = 3'h5, TMR8_CS_EXT_FALL = 3'h6,
    TMR8_CS_EXT_RISE = 3'h7
  } tmr8_cs_t;

  // Counting classes, Gray coded.
  typedef enum logic [1:0] {
    TMR8_CLS_NORMAL = 2'b00, TMR8_CLS_CTC = 2'b01, TMR8_CLS_FAST = 2'b11,
    TMR8_CLS_PHASE = 2'b10
  } tmr8_cls_t;

  typedef enum logic {TMR8_UP = 1'b0, TMR8_DOWN = 1'b1} tmr8_dir_t;

endpackage

// ### verilog/tmr8_wave.sv
// Eight-bit timer with two compare-match waveform outputs, behind an APB slave.
// Assumes pclk is the I/O clock; t0_pin is asynchronous; pin wire is resolved outside.
//
// How it works
// - Nonzero A behaviour field hands pin A to the waveform; driver needs direction bit.
// - Non-PWM A field: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 01 toggles only with mode bit2; 10/11 match and TOP actions.
// - PWM A: compare A equal TOP with upper bit set ignores match, acts at TOP.
// - Dual-slope A: 10 clears up, sets down; 11 reverse; 01 toggles if bit2.
// - Nonzero B behaviour field hands pin B to the waveform; driver needs direction bit.
// - Non-PWM B field: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM B: 01 reserved; 10 clear match set TOP; 11 reverse.
// - PWM B: compare B equal TOP with upper bit set ignores match, acts at TOP.
// - Dual-slope B: 10 clears up, sets down; 11 reverse; 01 reserved.
// - Bits 3 and 2 of timer_control_a read as zero.
// - Wave mode is bit2 from control B plus two low bits of control A.
// - TOP is MAX in modes 0,1,3 and compare A in 2,5,7; 4,6 reserved.
// - Compares update at once in 0,2, at TOP in PWM; wrap flag timing per mode.
// - MAX is the fixed counter value 0xff.
// - Everything on the I/O clock; counting and flags only on tick enable cycles.
// - B flag sets on every B match; A flag on A matches.
// - In clear-on-match and fast PWM with A as TOP, A match sets flag, clears counter.
// - Tick source: stopped, divide 1/8/64/256/1024, external falling or rising edge.
`timescale 1ns/1ps

module tmr8_wave
  import tmr8_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       t0_pin,
  output logic            wave_out_a,
  output logic            wave_out_a_oe,
  output logic            wave_out_b,
  output logic            wave_out_b_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic        mode_bit2;
    logic [2:0]  tick_sel;
    logic [7:0]  count;
    tmr8_dir_t   dir;
    logic        block;
    logic [7:0]  cmp_a_buf;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b_buf;
    logic [7:0]  cmp_b;
    logic [2:0]  flags;
    logic        force_a;
    logic        force_b;
    logic        oc_a;
    logic        oc_b;
    logic [7:0]  port;
    logic [9:0]  pre;
    logic        t0_s1;
    logic        t0_s2;
    logic        t0_s3;
    logic        t0_lvl;
    logic        pin_a;
    logic        pin_a_oe;
    logic        pin_b;
    logic        pin_b_oe;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } tmr8_state_t;

  tmr8_state_t st;
  tmr8_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Output compare action for one channel.

  function automatic logic tmr8_oc_next(input logic      oc,
                                        input logic [1:0] beh,
                                        input tmr8_cls_t cls,
                                        input logic      tog_ok,
                                        input logic      match,
                                        input logic      at_top,
                                        input tmr8_dir_t dir,
                                        input logic      eq_top);
    logic r;
    logic ign;
    r   = oc;
    ign = eq_top & beh[1];
    case (cls)
      TMR8_CLS_FAST: begin
        if (beh == 2'b01) begin
          if (tog_ok && match) r = ~oc;
        end else if (beh[1]) begin
          if (match && !ign) r = beh[0];
          else if (at_top) r = ~beh[0];
        end
      end
      TMR8_CLS_PHASE: begin
        if (beh == 2'b01) begin
          if (tog_ok && match) r = ~oc;
        end else if (beh[1]) begin
          if (ign) begin
            if (at_top) r = ~beh[0];
          end else if (match) begin
            r = beh[0] ^ (dir == TMR8_DOWN);
          end
        end
      end
      default: begin
        if (match) begin
          case (beh)
            2'b01:   r = ~oc;
            2'b10:   r = 1'b0;
            2'b11:   r = 1'b1;
            default: r = oc;
          endcase
        end
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of mode, tick and counter events.

  logic [2:0]  mode;
  tmr8_cls_t   cls;
  logic        pwm;
  logic        top_is_a;
  logic [7:0]  top;
  logic        at_top;
  logic        ext_edge;
  logic        tick;
  logic        match_a;
  logic        match_b;
  logic        wrap;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;

  always_comb begin
    mode     = {st.mode_bit2, st.ctrl_a[1:0]};
    case (mode)
      3'd1, 3'd5: cls = TMR8_CLS_PHASE;
      3'd2:       cls = TMR8_CLS_CTC;
      3'd3, 3'd7: cls = TMR8_CLS_FAST;
      default:    cls = TMR8_CLS_NORMAL;
    endcase
    pwm      = (cls == TMR8_CLS_FAST) || (cls == TMR8_CLS_PHASE);
    top_is_a = (mode == 3'd2) || (mode == 3'd5) || (mode == 3'd7);
    top      = top_is_a ? st.cmp_a : TMR8_MAX;
    at_top   = (st.count == top);
    ext_edge = (st.t0_s2 == st.t0_s3) && (st.t0_s3 != st.t0_lvl);
    case (tmr8_cs_t'(st.tick_sel))
      TMR8_CS_DIV1:     tick = 1'b1;
      TMR8_CS_DIV8:     tick = (st.pre[2:0] == TMR8_DIV8[2:0]);
      TMR8_CS_DIV64:    tick = (st.pre[5:0] == TMR8_DIV64[5:0]);
      TMR8_CS_DIV256:   tick = (st.pre[7:0] == TMR8_DIV256[7:0]);
      TMR8_CS_DIV1024:  tick = (st.pre == TMR8_DIV1024);
      TMR8_CS_EXT_FALL: tick = ext_edge && !st.t0_s3;
      TMR8_CS_EXT_RISE: tick = ext_edge && st.t0_s3;
      default:          tick = 1'b0;
    endcase
    match_a  = tick && !st.block && (st.count == st.cmp_a);
    match_b  = tick && !st.block && (st.count == st.cmp_b);
    if (cls == TMR8_CLS_PHASE)
      wrap = tick && (st.count == TMR8_BOTTOM) && (st.dir == TMR8_DOWN);
    else if (mode == 3'd7)
      wrap = tick && at_top;
    else
      wrap = tick && (st.count == TMR8_MAX);
    // A write lands at the edge where pready is sampled high.
    wr       = psel && penable && pwrite && st.ready;
    rd       = psel && penable && !pwrite && !st.ready;
    wbyte    = pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st = st;
    // External input: three stages, a change counts once stages two and three agree.
    next_st.t0_s1 = t0_pin;
    next_st.t0_s2 = st.t0_s1;
    next_st.t0_s3 = st.t0_s2;
    if (st.t0_s2 == st.t0_s3) next_st.t0_lvl = st.t0_s3;
    next_st.pre = 10'(st.pre + 10'd1);

    // Counter.
    if (tick) begin
      next_st.block = 1'b0;
      case (cls)
        TMR8_CLS_PHASE: begin
          if (st.dir == TMR8_UP) begin
            if (at_top) begin
              next_st.dir   = TMR8_DOWN;
              next_st.count = 8'(st.count - 8'd1);
            end else begin
              next_st.count = 8'(st.count + 8'd1);
            end
          end else if (st.count == TMR8_BOTTOM) begin
            next_st.dir   = TMR8_UP;
            next_st.count = 8'(st.count + 8'd1);
          end else begin
            next_st.count = 8'(st.count - 8'd1);
          end
        end
        TMR8_CLS_CTC, TMR8_CLS_FAST:
          next_st.count = at_top ? TMR8_BOTTOM : 8'(st.count + 8'd1);
        default:
          next_st.count = 8'(st.count + 8'd1);
      endcase
    end

    // Compare registers: at once outside PWM, at TOP in PWM.
    if (!pwm || (tick && at_top)) begin
      next_st.cmp_a = st.cmp_a_buf;
      next_st.cmp_b = st.cmp_b_buf;
    end

    // Waveform levels, on tick cycles only.
    if (tick) begin
      next_st.oc_a = tmr8_oc_next(st.oc_a, st.ctrl_a[TMR8_A_BEH_HI:TMR8_A_BEH_LO], cls,
                                  st.mode_bit2, match_a || (!pwm && st.force_a), at_top,
                                  st.dir, st.cmp_a == top);
      next_st.oc_b = tmr8_oc_next(st.oc_b, st.ctrl_a[TMR8_B_BEH_HI:TMR8_B_BEH_LO], cls,
                                  1'b0, match_b || (!pwm && st.force_b), at_top,
                                  st.dir, st.cmp_b == top);
      next_st.force_a = 1'b0;
      next_st.force_b = 1'b0;
    end

    // Flags: hardware set wins over a write-one clear.
    if (wr && paddr == TMR8_OFS_FLAGS)
      next_st.flags = st.flags & ~wbyte[2:0];
    if (wrap)    next_st.flags[TMR8_FLAG_WRAP] = 1'b1;
    if (match_a) next_st.flags[TMR8_FLAG_A] = 1'b1;
    if (match_b) next_st.flags[TMR8_FLAG_B] = 1'b1;

    // Register writes.
    if (wr) begin
      if (paddr == TMR8_OFS_CTRL_A) begin
        next_st.ctrl_a = wbyte & TMR8_CTRL_A_MASK;
      end else if (paddr == TMR8_OFS_CTRL_B) begin
        next_st.mode_bit2 = wbyte[TMR8_MODE_BIT2];
        next_st.tick_sel  = wbyte[2:0];
        if (!pwm && wbyte[TMR8_FORCE_A]) next_st.force_a = 1'b1;
        if (!pwm && wbyte[TMR8_FORCE_B]) next_st.force_b = 1'b1;
      end else if (paddr == TMR8_OFS_COUNT) begin
        next_st.count = wbyte;
        next_st.block = 1'b1;
      end else if (paddr == TMR8_OFS_CMP_A) begin
        next_st.cmp_a_buf = wbyte;
      end else if (paddr == TMR8_OFS_CMP_B) begin
        next_st.cmp_b_buf = wbyte;
      end else if (paddr == TMR8_OFS_PORT) begin
        next_st.port = wbyte & TMR8_PORT_MASK;
      end
    end

    // Pins: waveform takes over when its field is nonzero.
    next_st.pin_a    = (st.ctrl_a[TMR8_A_BEH_HI:TMR8_A_BEH_LO] != 2'b00) ? next_st.oc_a
                                                                       : st.port[TMR8_DATA_A];
    next_st.pin_a_oe = st.port[TMR8_DIR_A];
    next_st.pin_b    = (st.ctrl_a[TMR8_B_BEH_HI:TMR8_B_BEH_LO] != 2'b00) ? next_st.oc_b
                                                                       : st.port[TMR8_DATA_B];
    next_st.pin_b_oe = st.port[TMR8_DIR_B];

    // APB answer one cycle into the access phase.
    next_st.ready = psel && penable && !st.ready;
    next_st.err   = 1'b0;
    next_st.rdata = 32'h0000_0000;
    if (psel && penable && !st.ready) begin
      if (paddr == TMR8_OFS_CTRL_A) begin
        next_st.rdata = {24'h000000, st.ctrl_a & TMR8_CTRL_A_MASK};
      end else if (paddr == TMR8_OFS_CTRL_B) begin
        next_st.rdata = {24'h000000, 4'h0, st.mode_bit2, st.tick_sel};
      end else if (paddr == TMR8_OFS_COUNT) begin
        next_st.rdata = {24'h000000, st.count};
      end else if (paddr == TMR8_OFS_CMP_A) begin
        next_st.rdata = {24'h000000, st.cmp_a_buf};
      end else if (paddr == TMR8_OFS_CMP_B) begin
        next_st.rdata = {24'h000000, st.cmp_b_buf};
      end else if (paddr == TMR8_OFS_FLAGS) begin
        next_st.rdata = {24'h000000, 5'h00, st.flags};
      end else if (paddr == TMR8_OFS_PORT) begin
        next_st.rdata = {24'h000000, st.port};
      end else begin
        next_st.err = 1'b1;
      end
      if (!rd) next_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.ctrl_a <= TMR8_RST_CTRL_A;
      st.port   <= TMR8_RST_BYTE;
      st.dir    <= TMR8_UP;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.rdata;
  assign pready        = st.ready;
  assign pslverr       = st.err;
  assign wave_out_a    = st.pin_a;
  assign wave_out_a_oe = st.pin_a_oe;
  assign wave_out_b    = st.pin_b;
  assign wave_out_b_oe = st.pin_b_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_a_hold: assert property (!tick |=> $stable(st.oc_a) && $stable(st.oc_b))
    else $error("Waveform level changed without a tick.");
  a_count_hold: assert property (!tick && !wr |=> $stable(st.count))
    else $error("Counter moved without a tick.");
  a_flag_b_set: assert property (match_b |=> st.flags[TMR8_FLAG_B])
    else $error("B flag missed a B match.");
  a_ctc_clear: assert property (tick && !wr && cls == TMR8_CLS_CTC && at_top
                                |=> st.count == TMR8_BOTTOM)
    else $error("Counter not cleared on A match in clear-on-match mode.");
  a_reserved_zero: assert property (st.ready && !pwrite
                                    && paddr == TMR8_OFS_CTRL_A |-> prdata[3:2] == 2'b00)
    else $error("Reserved control bits read nonzero.");
  a_nonpwm_set: assert property (tick && !pwm && match_a
                                 && st.ctrl_a[7:6] == 2'b11 |=> st.oc_a)
    else $error("Output A not set on match.");
  a_fast_top: assert property (tick && cls == TMR8_CLS_FAST && at_top && !match_b
                               && st.ctrl_a[5:4] == 2'b10 |=> st.oc_b)
    else $error("Output B not set at TOP in fast PWM.");
  a_phase_down: assert property (tick && cls == TMR8_CLS_PHASE && match_a
                                 && st.dir == TMR8_DOWN && st.ctrl_a[7:6] == 2'b10
                                 && st.cmp_a != top |=> st.oc_a)
    else $error("Output A not set on down-counting match.");
  a_wrap_max: assert property (tick && !pwm && st.count == TMR8_MAX
                               |=> st.flags[TMR8_FLAG_WRAP])
    else $error("Wrap flag not set at MAX.");
  a_pin_owner: assert property (st.ctrl_a[7:6] != 2'b00 && $stable(st.ctrl_a)
                                |=> wave_out_a == st.oc_a)
    else $error("Pin A not driven by the waveform.");
  a_div8_rate: assert property (st.tick_sel == 3'd2 && tick
                                |=> !tick [*7])
    else $error("Divide-by-8 tick too frequent.");
  a_phase_wrap: assert property (tick && cls == TMR8_CLS_PHASE
                                 && st.count == TMR8_BOTTOM && st.dir == TMR8_DOWN
                                 |=> st.flags[TMR8_FLAG_WRAP])
    else $error("Wrap flag not set at BOTTOM in dual-slope PWM.");
  a_pin_b_owner: assert property (st.ctrl_a[5:4] != 2'b00
                                  |=> wave_out_b == st.oc_b)
    else $error("Pin B not driven by the waveform.");

  c_ctc_match:   cover property (tick && cls == TMR8_CLS_CTC && at_top);
  c_fast_cycle:  cover property (tick && cls == TMR8_CLS_FAST && at_top);
  c_phase_turn:  cover property (tick && cls == TMR8_CLS_PHASE && st.dir == TMR8_DOWN
                                 && st.count == TMR8_BOTTOM);
  c_flag_clash:  cover property (match_a && wr && paddr == TMR8_OFS_FLAGS);

endmodule

// ### tb/tmr8_wave_bench.sv
// Self-checking bench for the eight-bit timer with two waveform outputs.
// Assumes the design answers APB with one wait state and runs on a 125 MHz pclk.
`timescale 1ns/1ps

module tmr8_wave_bench
  import tmr8_pkg::*;
;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        t0_pin;
  logic        wave_out_a;
  logic        wave_out_a_oe;
  logic        wave_out_b;
  logic        wave_out_b_oe;
  int          bad_count;
  int          check_count;
  int          cycles;
  logic [31:0] rd;
  logic        err;
  int          ha;
  int          hb;
  logic [1:0]  beh_tab [4] = '{2'b01, 2'b10, 2'b11, 2'b01};
  logic        lvl_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tmr8_wave uut (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .t0_pin        (t0_pin),
    .wave_out_a    (wave_out_a),
    .wave_out_a_oe (wave_out_a_oe),
    .wave_out_b    (wave_out_b),
    .wave_out_b_oe (wave_out_b_oe)
  );

  always #4 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Counts high cycles of both pins over n cycles, whole periods of the waveform.
  task automatic measure(input int n = 512);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(posedge pclk);
      if (wave_out_a === 1'b1) ha++;
      if (wave_out_b === 1'b1) hb++;
    end
  endtask

  // Stops the counter, loads both compares, sets the count to ca and restarts it.
  task automatic restart(input logic [7:0] ca, input logic [7:0] ctl_a, input logic [7:0] cmp_a,
                         input logic [7:0] cmp_b, input logic [7:0] ctl_b);
    wr(TMR8_OFS_CTRL_B, 8'h00);
    wr(TMR8_OFS_CTRL_A, ctl_a);
    wr(TMR8_OFS_CMP_A, cmp_a);
    wr(TMR8_OFS_CMP_B, cmp_b);
    wr(TMR8_OFS_FLAGS, 8'h07);
    wr(TMR8_OFS_COUNT, ca);
    wr(TMR8_OFS_CTRL_B, ctl_b);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t0_pin = 1'b0;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check({28'h0, wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe}, 32'h0);
    rd_chk(TMR8_OFS_CTRL_A, {24'h0, TMR8_RST_CTRL_A});
    rd_chk(TMR8_OFS_CTRL_B, {24'h0, TMR8_RST_CTRL_B});
    wr(TMR8_OFS_CTRL_A, 8'hff);
    rd_chk(TMR8_OFS_CTRL_A, 32'h0000_00f3);
    rd_chk(8'h1c, 32'h0);
    check({31'h0, err}, 32'h1);
    // Fields at zero leave the pins to port data and direction.
    wr(TMR8_OFS_CTRL_A, 8'h00);
    wr(TMR8_OFS_PORT, 8'h33);
    repeat (3) @(posedge pclk);
    check({28'h0, wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe}, 32'hf);
    wr(TMR8_OFS_PORT, 8'h03);
    // Normal mode: toggle, clear, set, toggle on matches at 0x10 and 0x20.
    for (int i = 0; i < 4; i++) begin
      restart(8'h00, {beh_tab[i], beh_tab[i], 4'h0}, 8'h10, 8'h20, 8'h01);
      repeat (40) @(posedge pclk);
      check({30'h0, wave_out_a, wave_out_b}, {30'h0, lvl_tab[i], lvl_tab[i]});
      if (i == 0) rd_chk(TMR8_OFS_FLAGS, 32'h6);
    end
    check({30'h0, wave_out_a_oe, wave_out_b_oe}, 32'h3);
    // Clear-on-match mode with compare A at 5.
    restart(8'h00, 8'h02, 8'h05, 8'h20, 8'h01);
    repeat (30) @(posedge pclk);
    repeat (3) begin
      apb(1'b0, TMR8_OFS_COUNT, 32'h0);
      check({31'h0, rd[7:0] <= 8'h05}, 32'h1);
    end
    rd_chk(TMR8_OFS_FLAGS, 32'h2);
    // Normal mode from 0xf8: the wrap flag sets when the count passes MAX.
    restart(8'hf8, 8'h00, 8'h80, 8'h80, 8'h01);
    repeat (20) @(posedge pclk);
    rd_chk(TMR8_OFS_FLAGS, 32'h1);
    // Divide by 8: some eighty enabled edges give ten or eleven ticks.
    restart(8'h00, 8'h00, 8'h80, 8'h80, 8'h02);
    repeat (80) @(posedge pclk);
    apb(1'b0, TMR8_OFS_COUNT, 32'h0);
    check({31'h0, rd[7:0] >= 8'h0a && rd[7:0] <= 8'h0b}, 32'h1);
    // External input: five pulses give five counts on the falling, then the rising edge.
    for (int s = 6; s < 8; s++) begin
      restart(8'h00, 8'h00, 8'h80, 8'h80, 8'(s));
      repeat (5) begin
        t0_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        t0_pin <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      rd_chk(TMR8_OFS_COUNT, 32'h5);
    end
    // Fast PWM with TOP at MAX: A non-inverted at 0x80, B inverted at 0x40.
    restart(8'h00, 8'hb3, 8'h80, 8'h40, 8'h01);
    repeat (600) @(posedge pclk);
    measure();
    check(ha, 32'd258);
    check(hb, 32'd382);
    apb(1'b0, TMR8_OFS_FLAGS, 32'h0);
    check(rd & 32'h1, 32'h1);
    // Compare A at TOP: the match is ignored and the pin stays set.
    wr(TMR8_OFS_CMP_A, 8'hff);
    repeat (600) @(posedge pclk);
    measure();
    check(ha, 32'd512);
    // Mode 7: TOP from compare A, A toggles on match, B clears at 0x10.
    restart(8'h00, 8'h63, 8'h3f, 8'h10, 8'h09);
    repeat (600) @(posedge pclk);
    measure();
    check(ha, 32'd256);
    check(hb, 32'd136);
    // Dual-slope PWM with TOP at MAX: A non-inverted at 0x80, B inverted at 0x40.
    restart(8'h00, 8'hb1, 8'h80, 8'h40, 8'h01);
    repeat (600) @(posedge pclk);
    measure(510);
    check(ha, 32'd256);
    check(hb, 32'd382);
    apb(1'b0, TMR8_OFS_FLAGS, 32'h0);
    check(rd & 32'h1, 32'h1);
    complete_run();
  end

endmodule
